// file: ctdc_defines.svh
/*
  Register map, field positions, reset values and fixed figures of the tick down counter.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef CTDC_DEFINES_SVH
`define CTDC_DEFINES_SVH

`define CTDC_OFS_CTRL     32'he000e010
`define CTDC_OFS_LOAD     32'he000e014
`define CTDC_OFS_LIVE     32'he000e018
`define CTDC_OFS_CAL      32'he000e01c

`define CTDC_BIT_ENABLE   0
`define CTDC_BIT_IRQEN    1
`define CTDC_BIT_CLKSEL   2
`define CTDC_BIT_HIT      16

`define CTDC_RST_CTRL     32'h00000004
`define CTDC_RST_LOAD     24'h000000
`define CTDC_RST_LIVE     24'h000000
`define CTDC_CAL_COUNT    24'h002904
`define CTDC_DIV_RATIO    4'h8

`endif

// file: ctdc_pkg.sv
/*
  Types of the tick down counter.
  Assumes ctdc_defines.svh is on the include path.
*/
package ctdc_pkg;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } ctdc_wb_req_t;

  // Bus slave phase
  typedef enum logic [0:0] {
    CTDC_BUS_IDLE = 1'b0,
    CTDC_BUS_ACK  = 1'b1
  } ctdc_bus_t;

  // Whole state of the block
  typedef struct packed {
    ctdc_bus_t   bus;
    logic        ack;
    logic        err;
    logic [31:0] rdat;
    logic        enable;
    logic        irq_en;
    logic        clk_sel;
    logic        hit;
    logic        irq;
    logic        armed;
    logic [23:0] reload;
    logic [23:0] count;
    logic [2:0]  div;
  } ctdc_state_t;

endpackage : ctdc_pkg

// file: ctdc_timer.sv
/*
  Tick down counter with a classic Wishbone register slave.
  Assumes one clock ref_clk, aligned 32-bit word access, and a debug-halt level input.
*/
`timescale 1ns/1ps
`include "ctdc_defines.svh"

// What this block does
// RULE_01: 24-bit down counter reloading after zero
// RULE_02: Counter holds while processor is debug-halted
// RULE_03: Hit flag set at zero, read clears
// RULE_04: Clock select: 0 divide by 8, 1 direct
// RULE_05: Irq enable gates request on reaching zero
// RULE_06: Enable loads reload value then counts
// RULE_07: At zero: flag, optional request, reload
// RULE_08: Reload field 24 bits, upper bits reserved
// RULE_09: Only one-to-zero step raises flag/request
// RULE_10: Software uses N-1 periodic, N single
// RULE_11: Current value read returns live count
// RULE_12: Current value write clears count and flag
// RULE_13: Calibration read-only, fixed count, top zero
// RULE_14: Counter stops when processor clock stops
// RULE_15: Software uses aligned word accesses only
// RULE_16: Reserved bits read zero, writes ignored
// RULE_17: Cleared count reloads silently on next tick
module ctdc_timer
  import ctdc_pkg::*;
#(
  parameter logic [23:0] CAL_COUNT = `CTDC_CAL_COUNT  // Fixed calibration count
) (
  input  wire logic        ref_clk,     // Processor clock
  input  wire logic        rst_b,       // Async reset, active low
  input  wire logic        clk_en,      // Freezes all state when low
  input  wire logic        dbg_halt,    // Processor halted for debug
  input  wire logic        wb_cyc_i,    // Wishbone cycle
  input  wire logic        wb_stb_i,    // Wishbone strobe
  input  wire logic        wb_we_i,     // Wishbone write
  input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
  input  wire logic [31:0] wb_adr_i,    // Wishbone byte address
  input  wire logic [31:0] wb_dat_i,    // Wishbone write data
  output logic      [31:0] wb_dat_o,    // Wishbone read data
  output logic             wb_ack_o,    // Wishbone acknowledge
  output logic             wb_err_o,    // Wishbone error, unmapped or partial
  output logic             tick_irq_o   // Tick exception request, one pulse
);

  ctdc_state_t  s_q;                    // Registered state
  ctdc_state_t  s_d;                    // Next state
  ctdc_wb_req_t req;                    // Bundled request

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};

  // Outputs straight from flip-flops
  assign wb_dat_o   = s_q.rdat;
  assign wb_ack_o   = s_q.ack;
  assign wb_err_o   = s_q.err;
  assign tick_irq_o = s_q.irq;

  logic        hit_ctrl;   // Address decodes
  logic        hit_load;   // Start value selected
  logic        hit_live;   // Live count selected
  logic        hit_cal;    // Calibration word selected
  logic        take;       // Request accepted this cycle
  logic        good;       // Mapped and full word
  logic        tick;       // Counter step enable
  logic        zero_step;  // Counter moves from one to zero
  logic [31:0] rd_word;    // Read mux

  // Decode and tick generation
  always_comb begin
    hit_ctrl = (req.adr == `CTDC_OFS_CTRL);
    hit_load = (req.adr == `CTDC_OFS_LOAD);
    hit_live = (req.adr == `CTDC_OFS_LIVE);
    hit_cal  = (req.adr == `CTDC_OFS_CAL);
    // Only one access at a time; the ack cycle ignores the bus
    take     = req.cyc && req.stb && (s_q.bus == CTDC_BUS_IDLE);
    // Partial-word access is refused rather than half-applied
    good     = (hit_ctrl || hit_load || hit_live || hit_cal) && (req.sel == 4'hf); // RULE_15
    // Divided tick fires on the last prescaler state only
    tick     = s_q.enable && !dbg_halt &&
               (s_q.clk_sel || (s_q.div == 3'(`CTDC_DIV_RATIO - 4'h1))); // RULE_02 RULE_04
    zero_step = tick && s_q.armed && (s_q.count == 24'h000001); // RULE_09
    rd_word  = 32'h00000000;  // Reserved bits read zero  // RULE_16
    if (hit_ctrl) begin
      rd_word[`CTDC_BIT_ENABLE] = s_q.enable;
      rd_word[`CTDC_BIT_IRQEN]  = s_q.irq_en;
      rd_word[`CTDC_BIT_CLKSEL] = s_q.clk_sel;
      rd_word[`CTDC_BIT_HIT]    = s_q.hit;
    end else if (hit_load) begin
      rd_word[23:0] = s_q.reload; // RULE_08
    end else if (hit_live) begin
      rd_word[23:0] = s_q.count;  // RULE_11
    end else if (hit_cal) begin
      rd_word[23:0] = CAL_COUNT;  // RULE_13
    end
  end

  // Next-state logic
  always_comb begin
    s_d     = s_q;
    s_d.irq = 1'b0;
    // Prescaler runs only while enabled, so a fresh enable starts a full period
    if (s_q.enable && !dbg_halt) begin
      s_d.div = s_q.div + 3'h1;
    end
    // Counter step
    if (tick) begin
      if (s_q.count == 24'h000000) begin
        s_d.count = s_q.reload;  // RULE_01 RULE_17
        s_d.armed = 1'b1;
      end else begin
        s_d.count = s_q.count - 24'h000001; // RULE_01
      end
    end
    // Bus slave: one wait state, ack for one cycle
    case (s_q.bus)
      CTDC_BUS_IDLE: begin
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        if (take) begin
          s_d.bus  = CTDC_BUS_ACK;
          s_d.ack  = good;
          s_d.err  = !good;
          s_d.rdat = (good && !req.we) ? rd_word : 32'h00000000;
          // Control write; reserved bits are simply not stored
          if (good && req.we && hit_ctrl) begin
            s_d.irq_en  = req.dat[`CTDC_BIT_IRQEN];
            s_d.clk_sel = req.dat[`CTDC_BIT_CLKSEL];
            s_d.enable  = req.dat[`CTDC_BIT_ENABLE];
            // Only a rising enable reloads; writing enable while already enabled keeps the count
            if (req.dat[`CTDC_BIT_ENABLE] && !s_q.enable) begin
              s_d.count = req.dat[`CTDC_BIT_ENABLE] ? s_q.reload : s_q.count; // RULE_06
              s_d.div   = 3'h0;
              s_d.armed = 1'b1;
            end
          end
          // Upper byte of the start value is dropped
          if (good && req.we && hit_load) begin
            s_d.reload = req.dat[23:0]; // RULE_08 RULE_16
          end
          // Any full-word write to the live count clears it and the flag
          if (good && req.we && hit_live) begin
            s_d.count = 24'h000000; // RULE_12
            s_d.hit   = 1'b0;       // RULE_12
            s_d.armed = 1'b0;       // RULE_17
          end
          // Status read hands the flag over and clears it
          if (good && !req.we && hit_ctrl) begin
            s_d.hit = 1'b0; // RULE_03
          end
        end
      end
      CTDC_BUS_ACK: begin
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.bus = CTDC_BUS_IDLE;
      end
      default: begin
        s_d.bus = CTDC_BUS_IDLE;
      end
    endcase
    // Zero reach wins over any clear in the same cycle
    if (zero_step) begin
      s_d.hit = 1'b1;      // RULE_03 RULE_07
      s_d.irq = s_q.irq_en; // RULE_05 RULE_07
    end
  end

  // State register; clock enable models stopped processor clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q         <= '0;
      // Reset picks the undivided clock, as the control reset value says
      s_q.clk_sel <= 1'(`CTDC_RST_CTRL >> `CTDC_BIT_CLKSEL);
      s_q.reload  <= `CTDC_RST_LOAD;
      s_q.count   <= `CTDC_RST_LIVE;
    end else if (clk_en) begin // RULE_14
      s_q <= s_d;
    end
  end

  // Checks
  // Bus-side checks look one edge after the taking edge, where the
  // registered answer stands; a stopped clock enable is excluded
  // since nothing moves then and the answer is simply delayed.
  // Counter held in debug halt
  property p_halt_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && dbg_halt && !(take && req.we)) |=> $stable(s_q.count);
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("count moved in halt"); // RULE_02

  // Request needs the enable bit
  property p_irq_gate;
    @(posedge ref_clk) disable iff (!rst_b)
    tick_irq_o |-> $past(s_q.irq_en) && s_q.hit;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("request without enable"); // RULE_05

  // Flag raised on reaching zero
  property p_hit_set;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && zero_step) |=> s_q.hit && (s_q.count == 24'h000000);
  endproperty
  a_hit_set: assert property (p_hit_set) else $error("flag not set at zero"); // RULE_07

  // Zero reloads the start value
  property p_reload_after_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && tick && s_q.count == 24'h000000 && !(take && req.we)) |=>
      s_q.count == $past(s_q.reload);
  endproperty
  a_reload_after_zero: assert property (p_reload_after_zero) else $error("no reload"); // RULE_01

  // Live count write clears count and flag
  property p_live_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && req.we && hit_live && !zero_step) |=>
      s_q.count == 24'h000000 && !s_q.hit;
  endproperty
  a_live_clear: assert property (p_live_clear) else $error("value write no clear"); // RULE_12

  // Status read clears the flag
  property p_read_clear;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && !req.we && hit_ctrl && !zero_step) |=> !s_q.hit;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag not cleared by read"); // RULE_03

  // Calibration word is fixed
  property p_cal_read;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && !req.we && hit_cal) |=> wb_dat_o == {8'h00, CAL_COUNT};
  endproperty
  a_cal_read: assert property (p_cal_read) else $error("calibration wrong"); // RULE_13

  // Divided tick on last prescaler state
  property p_div_tick;
    @(posedge ref_clk) disable iff (!rst_b)
    (tick && !s_q.clk_sel) |-> s_q.div == 3'h7;
  endproperty
  a_div_tick: assert property (p_div_tick) else $error("divided tick early"); // RULE_04

  // Flag only from a one-to-zero step
  property p_no_silent_flag;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && !zero_step) |=> !$rose(s_q.hit);
  endproperty
  a_no_silent_flag: assert property (p_no_silent_flag) else $error("silent flag"); // RULE_09

  // Request only follows a one-to-zero step
  property p_irq_step;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && !zero_step) |=> !tick_irq_o;
  endproperty
  a_irq_step: assert property (p_irq_step) else $error("stray request"); // RULE_07

  // Enabled request follows the step
  property p_irq_on;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && zero_step && s_q.irq_en) |=> tick_irq_o;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("request missing"); // RULE_05

  // Masked step gives no request
  property p_irq_mask;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && zero_step && !s_q.irq_en) |=> !tick_irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked request"); // RULE_05

  // Each tick takes exactly one off a nonzero count
  property p_cnt_step;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && tick && s_q.count != 24'h000000 && !(take && req.we)) |=>
      s_q.count == $past(s_q.count) - 24'h000001;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count step wrong"); // RULE_01

  // Disabled counter holds its value
  property p_idle_hold;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && !s_q.enable && !(take && req.we)) |=> $stable(s_q.count);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("disabled count moved"); // RULE_06

  // Rising enable loads the start value
  property p_en_load;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && req.we && hit_ctrl && !s_q.enable &&
     req.dat[`CTDC_BIT_ENABLE]) |=> s_q.count == $past(s_q.reload);
  endproperty
  a_en_load: assert property (p_en_load) else $error("enable did not load"); // RULE_06

  // Stopped clock freezes every bit of state
  property p_freeze;
    @(posedge ref_clk) disable iff (!rst_b)
    !clk_en |=> $stable(s_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen"); // RULE_14

  // Prescaler also waits in debug halt
  property p_halt_div;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && dbg_halt && !(take && req.we)) |=> $stable(s_q.div);
  endproperty
  a_halt_div: assert property (p_halt_div) else $error("prescaler moved in halt"); // RULE_02

  // Start value keeps only the low 24 bits
  property p_load_wr;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && req.we && hit_load) |=>
      {8'h00, s_q.reload} == ($past(wb_dat_i) & 32'h00ffffff);
  endproperty
  a_load_wr: assert property (p_load_wr) else $error("start value not stored"); // RULE_08

  // Live read returns the count of the taking edge
  property p_live_rd;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && good && !req.we && hit_live) |=>
      wb_dat_o == {8'h00, $past(s_q.count)};
  endproperty
  a_live_rd: assert property (p_live_rd) else $error("live read wrong"); // RULE_11

  // Top byte of every answer is zero
  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    wb_ack_o |-> wb_dat_o[31:24] == 8'h00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // RULE_16

  // Reload from zero stays silent
  property p_quiet_rld;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && tick && s_q.count == 24'h000000) |=> !tick_irq_o;
  endproperty
  a_quiet_rld: assert property (p_quiet_rld) else $error("request at reload"); // RULE_17

  // Partial word access is answered with an error
  property p_err_sel;
    @(posedge ref_clk) disable iff (!rst_b)
    (clk_en && take && req.sel != 4'hf) |=> wb_err_o && !wb_ack_o;
  endproperty
  a_err_sel: assert property (p_err_sel) else $error("partial access taken"); // RULE_15

endmodule : ctdc_timer

// file: test_core_tick_down_counter.sv
/*
  Self-checking bench of the tick down counter: register table, then periods, freezes, flags.
  Assumes ctdc_pkg is compiled first and ctdc_defines.svh is on the include path.
*/
`timescale 1ns/1ps
`include "ctdc_defines.svh"
module test_core_tick_down_counter;
  import ctdc_pkg::*;
  localparam logic [31:0] CTRL_A = `CTDC_OFS_CTRL;  // Control and status
  localparam logic [31:0] LOAD_A = `CTDC_OFS_LOAD;  // Start value
  localparam logic [31:0] LIVE_A = `CTDC_OFS_LIVE;  // Live count
  localparam logic [31:0] CAL_A  = `CTDC_OFS_CAL;   // Calibration
  // One table row: access and its expected {err, read data}
  typedef struct packed {
    logic        we;
    logic [31:0] adr;
    logic [31:0] wd;
    logic [32:0] exp;
  } ctdc_row_t;
  logic         ref_clk;    // 200 MHz clock
  logic         rst_b;      // Reset, active low
  logic         clk_en;     // Processor clock running
  logic         dbg_halt;   // Debug halt
  ctdc_wb_req_t req;        // Bus request bundle
  logic [31:0]  rdat;       // Read data
  logic         ack;        // Acknowledge
  logic         err;        // Error answer
  logic         irq;        // Tick request
  logic [32:0]  got;        // Last answer
  int           error_cnt;  // Mismatches
  int           tests_run;  // Comparisons
  int           cyc_cnt;    // Cycles for timeout
  logic [3:0]   bsel;       // Byte selects of the next access
  int           n;          // Scratch count
  ctdc_row_t    rows [9];   // Register table cases

  ctdc_timer i_ctdc_timer (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .dbg_halt(dbg_halt),
    .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_sel_i(req.sel),
    .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .wb_err_o(err), .tick_irq_o(irq));

  // Clock, 5 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Cycle counter and hang guard; run needs well under 2000 cycles
  always @(posedge ref_clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 4000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Compare and count
  task chk(input logic [32:0] seen, input logic [32:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Classic single cycle; entered just after an edge, leaves one idle cycle
  task bus(input logic we, input logic [31:0] adr, input logic [31:0] wd);
    req <= '{1'b1, 1'b1, we, bsel, adr, wd};
    do @(posedge ref_clk); while (ack !== 1'b1 && err !== 1'b1);
    got = {err, rdat};
    req <= '0;
    @(posedge ref_clk);
  endtask : bus

  task rd(input logic [31:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0);
    chk(got, {1'b0, exp});
  endtask : rd

  // Cycles between two successive request pulses
  task gap(input int exp);
    do @(posedge ref_clk); while (irq !== 1'b1);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (irq !== 1'b1);
    chk(33'(n), 33'(exp));
  endtask : gap

  // No request pulse over c cycles
  task quiet(input int c);
    n = 0;
    repeat (c) begin
      @(posedge ref_clk);
      if (irq !== 1'b0) n++;
    end
    chk(33'(n), 33'h0);
  endtask : quiet

  task end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    dbg_halt = 1'b0;
    req = '0;
    bsel = 4'hf;
    rows = '{'{1'b0, CTRL_A, 32'h0, {1'b0, `CTDC_RST_CTRL}},
             '{1'b0, LOAD_A, 32'h0, 33'h0},
             '{1'b0, LIVE_A, 32'h0, 33'h0},
             '{1'b0, CAL_A, 32'h0, {9'h0, `CTDC_CAL_COUNT}},
             '{1'b1, LOAD_A, 32'hffffffff, 33'h0},
             '{1'b0, LOAD_A, 32'h0, 33'h000ffffff},
             '{1'b1, CAL_A, 32'hffffffff, 33'h0},
             '{1'b0, CAL_A, 32'h0, {9'h0, `CTDC_CAL_COUNT}},
             '{1'b0, 32'he000e020, 32'h0, 33'h100000000}};
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      bus(rows[i].we, rows[i].adr, rows[i].wd);
      chk(got, rows[i].exp);
    end
    $display("register table done");
    // Enable while halted: start value loaded, then held
    dbg_halt <= 1'b1;
    bus(1'b1, LOAD_A, 32'h5);
    bus(1'b1, CTRL_A, 32'h5);
    repeat (4) @(posedge ref_clk);
    rd(LIVE_A, 32'h5);
    dbg_halt <= 1'b0;
    // Direct clock, start value 3 gives a 4-cycle period
    bus(1'b1, LOAD_A, 32'h3);
    bus(1'b1, CTRL_A, 32'h7);
    gap(4);
    clk_en <= 1'b0;
    quiet(12);
    clk_en <= 1'b1;
    gap(4);
    dbg_halt <= 1'b1;
    quiet(12);
    dbg_halt <= 1'b0;
    gap(4);
    bus(1'b1, CTRL_A, 32'h6);
    rd(CTRL_A, 32'h00010006);
    rd(CTRL_A, 32'h00000006);
    $display("direct period done");
    // Divided clock: two ticks of 8 cycles
    bus(1'b1, LOAD_A, 32'h1);
    bus(1'b1, CTRL_A, 32'h3);
    gap(16);
    // Request masked, flag still set
    bus(1'b1, CTRL_A, 32'h5);
    quiet(20);
    rd(CTRL_A, 32'h00010005);
    $display("divided and masked done");
    // Live value write clears count and flag; zero start value stays silent
    bus(1'b1, CTRL_A, 32'h0);
    bus(1'b1, LOAD_A, 32'h0);
    bus(1'b1, LIVE_A, 32'hffffffff);
    rd(CTRL_A, 32'h0);
    rd(LIVE_A, 32'h0);
    bus(1'b1, CTRL_A, 32'h7);
    quiet(20);
    rd(CTRL_A, 32'h7);
    $display("clear and zero reload done");
    // Partial word write is refused and leaves the start value alone
    bsel = 4'h3;
    bus(1'b1, LOAD_A, 32'h7);
    chk(got, 33'h100000000);
    bsel = 4'hf;
    rd(LOAD_A, 32'h0);
    // Reset in mid-run brings every register back
    bus(1'b1, LOAD_A, 32'h9);
    rst_b <= 1'b0;
    @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rd(CTRL_A, `CTDC_RST_CTRL);
    rd(LOAD_A, 32'h0);
    rd(LIVE_A, 32'h0);
    $display("partial access and reset done");
    end_sim();
  end
endmodule : test_core_tick_down_counter
